// file: src/brg_regs.vh
// register offsets, field positions, reset values and mode tables of the bit-rate block
// assumes an apb slave with 32-bit data, one register per aligned word
`ifndef BRG_REGS_VH
`define BRG_REGS_VH

`define OFS_DIVISOR 5'h00
`define OFS_SERIAL_MODE 5'h04
`define OFS_CARD_MODE 5'h08
`define OFS_EXT_MODE 5'h0C
`define OFS_INFRARED 5'h10
`define OFS_CONTROL 5'h14
`define OFS_STATUS 5'h18

`define RST_DIVISOR 8'hFF
`define RST_CARD_CYCLES 3'h7

// serial_mode_register fields
`define SMR_SYNC_BIT 7
`define SMR_CYC1_BIT 3
`define SMR_CYC0_BIT 2
`define SMR_PRE_HI 1
`define SMR_PRE_LO 0
// card_mode_register fields
`define CARD_MODE_REGISTER_CYC2_BIT 7
`define CARD_MODE_REGISTER_CARD_BIT 0
// extension_mode_register fields
`define EXTENSION_MODE_REGISTER_HALF_BIT 3
// infrared_control fields
`define IR_EN_BIT 7
`define IR_W_HI 6
`define IR_W_LO 4
// control register fields
`define CTL_TE_BIT 5
`define CTL_RE_BIT 4

// basic clock cycles per bit
`define CPB_ASYNC16 10'h010
`define CPB_ASYNC8 10'h008
`define CPB_SYNC 10'h002
// 3/16 of a bit period
`define IR_NUM 12'h003
`define IR_DEN_SHIFT 4

`endif

// file: src/serial_bit_rate_generator.v
// bit-rate generator, mode selection and infrared pulse coding for serial channel zero
// assumes an apb master on clk_i and a framer on clk_i supplying transmit data
`timescale 1ns/1ps
`include "brg_regs.vh"

module serial_bit_rate_generator (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [31:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire pready_o,
  output wire pslverr_o,
  output reg [31:0] prdata_o,
  // framer side
  input wire tx_data_i,
  output reg rx_data_o,
  output reg basic_tick_o,
  output reg bit_tick_o,
  output wire card_mode_o,
  output wire sync_mode_o,
  // pins
  input wire channel0_receive_pin_i,
  output reg channel0_transmit_pin_o
);

  // ==========================================================
  // decoding helpers
  // ==========================================================
  function [9:0] card_cycles;
    input [2:0] code;
    begin
      case (code)
        3'h0: card_cycles = 10'h05D;
        3'h1: card_cycles = 10'h080;
        3'h2: card_cycles = 10'h0BA;
        3'h3: card_cycles = 10'h200;
        3'h4: card_cycles = 10'h020;
        3'h5: card_cycles = 10'h040;
        3'h6: card_cycles = 10'h174;
        default: card_cycles = 10'h100;
      endcase
    end
  endfunction

  // prescaler terminal value: 4^n - 1 clocks
  function [5:0] pre_last;
    input [1:0] n;
    begin
      case (n)
        2'h0: pre_last = 6'h00;
        2'h1: pre_last = 6'h03;
        2'h2: pre_last = 6'h0F;
        default: pre_last = 6'h3F;
      endcase
    end
  endfunction

  // ==========================================================
  // register file
  // ==========================================================
  reg [7:0] divisor_reg;
  reg [7:0] smr_reg;
  reg card_sel_reg;
  reg cyc2_reg;
  reg half_reg;
  reg [3:0] ir_reg;
  reg te_reg;
  reg re_reg;

  wire wr_en;
  wire rd_en;
  wire [4:0] ofs;
  wire mapped;
  wire idle;

  assign ofs = paddr_i[4:0];
  assign mapped = (paddr_i[31:5] == 27'h0000000) && (ofs[1:0] == 2'h0) && (ofs <= `OFS_STATUS);
  assign wr_en = psel_i && penable_i && pwrite_i && mapped;
  // reads are decoded in the setup cycle so the data stands at the access edge
  assign rd_en = psel_i && !penable_i && !pwrite_i;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;
  assign idle = !te_reg && !re_reg;

  // card and extension mode writes are dropped while either enable is set, so a running
  // generator never sees those change under it; serial mode writes are always taken
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      divisor_reg <= `RST_DIVISOR;
      smr_reg <= 8'h00;
      card_sel_reg <= 1'b0;
      cyc2_reg <= 1'b1;
      half_reg <= 1'b0;
      ir_reg <= 4'h0;
      te_reg <= 1'b0;
      re_reg <= 1'b0;
    end else if (wr_en) begin
      case (ofs)
        `OFS_DIVISOR: divisor_reg <= pwdata_i[7:0];
        `OFS_SERIAL_MODE: smr_reg <= pwdata_i[7:0];
        `OFS_CARD_MODE: begin
          if (idle) begin
            card_sel_reg <= pwdata_i[`CARD_MODE_REGISTER_CARD_BIT];
            cyc2_reg <= pwdata_i[`CARD_MODE_REGISTER_CYC2_BIT];
          end
        end
        `OFS_EXT_MODE: begin
          if (idle) begin
            half_reg <= pwdata_i[`EXTENSION_MODE_REGISTER_HALF_BIT];
          end
        end
        `OFS_INFRARED: ir_reg <= pwdata_i[7:4];
        `OFS_CONTROL: begin
          te_reg <= pwdata_i[`CTL_TE_BIT];
          re_reg <= pwdata_i[`CTL_RE_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // mode decode
  // ==========================================================
  wire [1:0] pre_n;
  wire [2:0] cyc_code;
  wire ir_en;
  wire [2:0] ir_width;
  wire stream_blocked;
  reg [9:0] cpb;

  assign pre_n = {smr_reg[`SMR_PRE_HI], smr_reg[`SMR_PRE_LO]};
  assign cyc_code = {cyc2_reg, smr_reg[`SMR_CYC1_BIT], smr_reg[`SMR_CYC0_BIT]};
  assign card_mode_o = card_sel_reg;
  assign sync_mode_o = !card_sel_reg && smr_reg[`SMR_SYNC_BIT];
  assign ir_en = ir_reg[3];
  assign ir_width = ir_reg[2:0];
  assign stream_blocked = sync_mode_o && (pre_n == 2'h0) && (divisor_reg == 8'h00);

  // basic clock cycles per bit for the selected mode
  // half select is ignored outside asynchronous mode
  always @* begin
    if (card_sel_reg) begin
      cpb = card_cycles(cyc_code);
    end else if (smr_reg[`SMR_SYNC_BIT]) begin
      cpb = `CPB_SYNC;
    end else if (half_reg) begin
      cpb = `CPB_ASYNC8;
    end else begin
      cpb = `CPB_ASYNC16;
    end
  end

  // ==========================================================
  // register read
  // ==========================================================
  // unmapped reads return zero instead of aliasing onto a low offset
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h00000000;
    end else if (rd_en && !mapped) begin
      prdata_o <= 32'h00000000;
    end else if (rd_en) begin
      case (ofs)
        `OFS_DIVISOR: prdata_o <= {24'h000000, divisor_reg};
        `OFS_SERIAL_MODE: prdata_o <= {24'h000000, smr_reg};
        `OFS_CARD_MODE: prdata_o <= {24'h000000, cyc2_reg, 6'h3F, card_sel_reg};
        `OFS_EXT_MODE: prdata_o <= {28'h0000000, half_reg, 3'h0};
        `OFS_INFRARED: prdata_o <= {24'h000000, ir_reg, 4'h0};
        `OFS_CONTROL: prdata_o <= {26'h0000000, te_reg, re_reg, 4'h0};
        `OFS_STATUS: prdata_o <= {20'h00000, stream_blocked, card_mode_o, cpb};
        default: prdata_o <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // baud generator: basic tick every 2 * 4^n * (N+1) clocks
  // ==========================================================
  reg [5:0] pre_cnt_reg;
  reg [7:0] div_cnt_reg;
  reg half_tog_reg;
  reg [9:0] bit_cnt_reg;
  wire run;
  wire pre_tick;
  wire div_tick;
  wire basic_tick;
  wire bit_tick;

  // a divisor change is picked up at the next reload, a prescale change at once;
  // the stopped generator preloads N so the first tick is a full period after enable
  assign run = te_reg || re_reg;
  assign pre_tick = (pre_cnt_reg >= pre_last(pre_n));
  assign div_tick = pre_tick && (div_cnt_reg == 8'h00);
  assign basic_tick = div_tick && half_tog_reg;
  assign bit_tick = basic_tick && (bit_cnt_reg >= cpb - 10'h001);

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_cnt_reg <= 6'h00;
      div_cnt_reg <= 8'h00;
      half_tog_reg <= 1'b0;
      bit_cnt_reg <= 10'h000;
      basic_tick_o <= 1'b0;
      bit_tick_o <= 1'b0;
    end else if (!run) begin
      pre_cnt_reg <= 6'h00;
      div_cnt_reg <= divisor_reg;
      half_tog_reg <= 1'b0;
      bit_cnt_reg <= 10'h000;
      basic_tick_o <= 1'b0;
      bit_tick_o <= 1'b0;
    end else begin
      pre_cnt_reg <= pre_tick ? 6'h00 : pre_cnt_reg + 6'h01;
      if (pre_tick) begin
        div_cnt_reg <= (div_cnt_reg == 8'h00) ? divisor_reg : div_cnt_reg - 8'h01;
      end
      if (div_tick) begin
        half_tog_reg <= !half_tog_reg;
      end
      if (bit_tick) begin
        bit_cnt_reg <= 10'h000;
      end else if (basic_tick) begin
        bit_cnt_reg <= bit_cnt_reg + 10'h001;
      end
      basic_tick_o <= basic_tick;
      bit_tick_o <= bit_tick;
    end
  end

  // ==========================================================
  // infrared transmit pulse coding
  // ==========================================================
  reg ir_pulse_reg;
  reg [7:0] ir_cnt_reg;
  wire [7:0] ir_last;
  wire [13:0] bit_pos;
  wire [13:0] ir_frac;
  wire ir_end;

  // nonzero codes count 2^k clocks from the bit tick; code 0 compares the
  // bit position scaled by 16 against 3 * cpb
  assign ir_last = (8'h01 << ir_width) - 8'h01;
  assign bit_pos = {bit_cnt_reg, 4'h0};
  assign ir_frac = {2'h0, `IR_NUM * {2'h0, cpb}};
  assign ir_end = (ir_width == 3'h0) ? (bit_pos >= ir_frac) : (ir_cnt_reg >= ir_last);

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ir_pulse_reg <= 1'b0;
      ir_cnt_reg <= 8'h00;
    end else if (!ir_en || !run) begin
      ir_pulse_reg <= 1'b0;
      ir_cnt_reg <= 8'h00;
    end else if (bit_tick && !tx_data_i) begin
      ir_pulse_reg <= 1'b1;
      ir_cnt_reg <= 8'h00;
    end else if (ir_pulse_reg) begin
      ir_pulse_reg <= !ir_end;
      ir_cnt_reg <= ir_cnt_reg + 8'h01;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      channel0_transmit_pin_o <= 1'b1;
    end else begin
      channel0_transmit_pin_o <= ir_en ? ir_pulse_reg : tx_data_i;
    end
  end

  // ==========================================================
  // receive pin: synchroniser and infrared pulse stretch
  // ==========================================================
  // only the second stage feeds logic; the first may be metastable
  reg rx_meta_reg;
  reg rx_sync_reg;
  reg rx_seen_reg;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end else begin
      rx_meta_reg <= channel0_receive_pin_i;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  // a high pulse marks a zero bit; the zero is held until a bit passes with no pulse
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_seen_reg <= 1'b0;
      rx_data_o <= 1'b1;
    end else if (!ir_en) begin
      rx_seen_reg <= 1'b0;
      rx_data_o <= rx_sync_reg;
    end else begin
      if (rx_sync_reg) begin
        rx_data_o <= 1'b0;
      end else if (bit_tick && !rx_seen_reg) begin
        rx_data_o <= 1'b1;
      end
      if (bit_tick) begin
        rx_seen_reg <= rx_sync_reg;
      end else if (rx_sync_reg) begin
        rx_seen_reg <= 1'b1;
      end
    end
  end

endmodule

// file: verification/line_partner.sv
// far-side serial partner: echoes the transmit pin back onto the receive pin
// assumes the bench clock and a lag chosen by the bench
`timescale 1ns/1ps
module line_partner (
  // clock and settings
  input wire clk_i,
  input wire [2:0] lag_i,
  // line
  input wire tx_pin_i,
  output wire rx_pin_o
);
  // ==========
  // echo line
  reg [7:0] dl = 8'hFF;
  always @(posedge clk_i) begin
    dl <= {dl[6:0], tx_pin_i};
  end
  // no serial clock is supplied, so the external clock limits are kept
  assign rx_pin_o = dl[lag_i];
endmodule

// file: verification/serial_bit_rate_generator_bench.sv
// self-checking bench for the bit-rate block
// assumes design, checker and line partner compiled first
`timescale 1ns/1ps
module serial_bit_rate_generator_bench;
  // ==========
  // stimulus and checking
  reg clk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg psel_i = 1'b0;
  reg penable_i = 1'b0;
  reg pwrite_i = 1'b0;
  reg [31:0] paddr_i = 32'h0;
  reg [31:0] pwdata_i = 32'h0;
  reg tx_data_i = 1'b1;
  reg [2:0] lag = 3'h1;
  wire pready_o, pslverr_o, rx_data_o, basic_tick_o, bit_tick_o;
  wire card_mode_o, sync_mode_o, channel0_receive_pin_i, channel0_transmit_pin_o;
  wire [31:0] prdata_o;
  wire [79:0] s_all = {10'h100, 10'h174, 10'h040, 10'h020, 10'h200, 10'h0BA, 10'h080, 10'h05D};
  reg [31:0] rv, t;
  reg [31:0] cyc = 32'h0;
  reg ev;
  integer n_fail = 0, n_tests = 0, i, w;
  serial_bit_rate_generator i_dut (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .prdata_o(prdata_o),
    .tx_data_i(tx_data_i),
    .rx_data_o(rx_data_o),
    .basic_tick_o(basic_tick_o),
    .bit_tick_o(bit_tick_o),
    .card_mode_o(card_mode_o),
    .sync_mode_o(sync_mode_o),
    .channel0_receive_pin_i(channel0_receive_pin_i),
    .channel0_transmit_pin_o(channel0_transmit_pin_o)
  );
  line_partner i_line (.clk_i(clk_i), .lag_i(lag), .tx_pin_i(channel0_transmit_pin_o),
    .rx_pin_o(channel0_receive_pin_i));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  task check(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: %h not %h", $time, got, exp);
      end
    end
  endtask
  task stop_test;
    begin
      if (n_fail == 0 && n_tests > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 32'h1;
    if (cyc == 32'hEA60) begin
      n_fail = n_fail + 1;
      stop_test;
    end
  end
  task apb(input w_i, input [31:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w_i;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      ev = pslverr_o;
      rv = prdata_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask
  task wr(input [31:0] a, input [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input [31:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      check(rv, e);
    end
  endtask
  task cfg(input [7:0] sm, input [7:0] cm, input [7:0] em, input [7:0] n, input [7:0] en);
    begin
      wr(32'h14, 32'h0);
      wr(32'h04, {24'h0, sm});
      wr(32'h08, {24'h0, cm});
      wr(32'h0C, {24'h0, em});
      wr(32'h00, {24'h0, n});
      wr(32'h14, {24'h0, en});
    end
  endtask
  // wait for the next basic or bit tick, bounded
  task wt(input b);
    begin
      w = 0;
      do begin
        @(posedge clk_i);
        #1 w = w + 1;
      end while ((b ? bit_tick_o : basic_tick_o) !== 1'b1 && w < 3000);
    end
  endtask
  task per(input b, input [31:0] e);
    begin
      wt(b);
      t = cyc;
      wt(b);
      check(cyc - t, e);
    end
  endtask
  // width of the next infrared pulse, two cycles of slack
  task pw(input [31:0] lo);
    integer h;
    begin
      h = 0;
      wt(1'b1);
      while (channel0_transmit_pin_o !== 1'b1 && w < 600) begin
        @(posedge clk_i);
        #1 w = w + 1;
      end
      while (channel0_transmit_pin_o === 1'b1 && h < 600) begin
        @(posedge clk_i);
        #1 h = h + 1;
      end
      check({31'h0, h >= lo && h <= lo + 2}, 32'h1);
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(32'h00, 32'hFF);
    rd(32'h04, 32'h0);
    rd(32'h08, 32'hFE);
    rd(32'h0C, 32'h0);
    rd(32'h10, 32'h0);
    rd(32'h14, 32'h0);
    rd(32'h20, 32'h0);
    check({31'h0, ev}, 32'h1);
    wr(32'h10, 32'hFF);
    rd(32'h10, 32'hF0);
    wr(32'h10, 32'h0);
    wr(32'h00, 32'h1A5);
    rd(32'h00, 32'hA5);
    cfg(8'h00, 8'h80, 8'h00, 8'h00, 8'h20);
    per(1'b0, 32'h2);
    per(1'b1, 32'h20);
    wr(32'h00, 32'h3C);
    rd(32'h00, 32'h3C);
    cfg(8'h00, 8'h80, 8'h08, 8'h00, 8'h10);
    per(1'b1, 32'h10);
    wr(32'h0C, 32'h0);
    rd(32'h0C, 32'h8);
    wr(32'h08, 32'h81);
    rd(32'h08, 32'hFE);
    cfg(8'h80, 8'h80, 8'h00, 8'h00, 8'h20);
    per(1'b1, 32'h4);
    check({31'h0, sync_mode_o}, 32'h1);
    rd(32'h18, 32'h802);
    for (i = 1; i < 4; i = i + 1) begin
      cfg(i, 8'h80, 8'h00, 8'h02, 8'h20);
      per(1'b0, 32'h6 << (2 * i));
    end
    for (i = 0; i < 8; i = i + 1) begin
      cfg({4'h0, i[1:0], 2'h0}, {i[2], 7'h01}, 8'h00, 8'h00, 8'h20);
      per(1'b1, 2 * s_all[i * 10 +: 10]);
      check({30'h0, card_mode_o, sync_mode_o}, 32'h2);
    end
    cfg(8'h01, 8'h01, 8'h00, 8'h00, 8'h20);
    per(1'b1, 32'h2E8);
    cfg(8'h00, 8'h80, 8'h00, 8'h07, 8'h20);
    tx_data_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    check({30'h0, channel0_transmit_pin_o, rx_data_o}, 32'h0);
    wr(32'h10, 32'h80);
    for (i = 0; i < 8; i = i + 1) begin
      wr(32'h10, 32'h80 | (i << 4));
      pw(i ? 32'h1 << i : 32'h30);
    end
    check({31'h0, rx_data_o}, 32'h0);
    @(posedge clk_i);
    tx_data_i <= 1'b1;
    lag <= 3'h5;
    wt(1'b1);
    wt(1'b1);
    wt(1'b1);
    check({31'h0, rx_data_o}, 32'h1);
    stop_test;
  end
endmodule
bind serial_bit_rate_generator serial_bit_rate_generator_sva i_sva (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .tx_data_i(tx_data_i),
  .rx_data_o(rx_data_o), .basic_tick_o(basic_tick_o), .bit_tick_o(bit_tick_o),
  .card_mode_o(card_mode_o), .sync_mode_o(sync_mode_o),
  .channel0_receive_pin_i(channel0_receive_pin_i),
  .channel0_transmit_pin_o(channel0_transmit_pin_o)
);

// file: verification/serial_bit_rate_generator_sva.sv
// port checker for the bit-rate block
// assumes a bind from the bench top file
`timescale 1ns/1ps
module serial_bit_rate_generator_sva (
  // watched ports
  input wire clk_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [31:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire tx_data_i,
  input wire rx_data_o,
  input wire basic_tick_o,
  input wire bit_tick_o,
  input wire card_mode_o,
  input wire sync_mode_o,
  input wire channel0_receive_pin_i,
  input wire channel0_transmit_pin_o
);
  // ==========
  // shadow of enables and infrared select
  wire wr = psel_i & penable_i & pwrite_i;
  wire w8 = wr && paddr_i == 32'h08;
  reg ir_q;
  reg [1:0] en_q;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ir_q <= 1'b0;
      en_q <= 2'h0;
    end else begin
      if (wr && paddr_i == 32'h10)
        ir_q <= pwdata_i[7];
      if (wr && paddr_i == 32'h14)
        en_q <= pwdata_i[5:4];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_mode_excl: assert property (!(card_mode_o && sync_mode_o))
    else $error("card and sync both set");
  a_card_set: assert property (w8 && en_q == 2'h0 |=> card_mode_o == $past(pwdata_i[0]))
    else $error("card select not taken");
  a_card_lock: assert property (w8 && en_q != 2'h0 |=> $stable(card_mode_o))
    else $error("card select changed while enabled");
  a_tick_pair: assert property (bit_tick_o |-> basic_tick_o)
    else $error("bit tick without basic tick");
  a_tick_gap: assert property (basic_tick_o |=> !basic_tick_o)
    else $error("basic tick longer than one cycle");
  a_idle_quiet: assert property ((en_q == 2'h0) [*3] |-> !basic_tick_o && !bit_tick_o)
    else $error("ticks while idle");
  a_pin_plain: assert property (!ir_q |=> channel0_transmit_pin_o == $past(tx_data_i))
    else $error("plain pin not one clock late");
  a_rx_pulse: assert property ((ir_q && channel0_receive_pin_i) [*3] |-> ##[0:2] !rx_data_o)
    else $error("infrared pulse not decoded");
  c_bit: cover property (bit_tick_o);
  c_card: cover property (card_mode_o && bit_tick_o);
  c_ir: cover property (ir_q && channel0_transmit_pin_o);
endmodule
